// File: rtl/ast_map.vh
`ifndef AST_MAP_VH
`define AST_MAP_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define AST_MCLK_HZ      40000000     // core clock rate
`define AST_REF_HZ       1000000      // reference input clock rate
`define AST_RX_HI_HZ     1000000      // rx sample clock, high speed
`define AST_RX_LO_HZ     125000       // rx sample clock, low speed
`define AST_DIV_HI       10           // bit rate divider, high speed
`define AST_DIV_LO       80           // bit rate divider, low speed
`define AST_RX_DIV_HI    9'h028       // core clocks per 1 MHz sample tick
`define AST_RX_DIV_LO    9'h140       // core clocks per 125 kHz sample tick
`define AST_TX_HALF_HI   11'h0C8      // core clocks per half bit, high rate
`define AST_TX_HALF_LO   11'h640      // core clocks per half bit, low rate
`define AST_CONFIRM      2'h2         // ticks from detect to confirm
`define AST_BREAK_TICKS  5'h09        // idle ticks that break a word
`define AST_NULL_TICKS   5'h0D        // idle ticks that frame a word
`define AST_IDLE_MAX     5'h1F        // idle counter saturation
`define AST_GAP_BITS     3'h4         // null bits between tx words
// ----------------------------------------
// word format
// ----------------------------------------
`define AST_LEN_LONG     6'h20        // 32 bit word
`define AST_LEN_SHORT    6'h19        // 25 bit word
`define AST_FIFO_FULL    4'h8         // fifo depth in words
`define AST_SD_X         8            // serial bit 9
`define AST_SD_Y         9            // serial bit 10
`define AST_PBIT_LONG    31           // parity slot, long word
`define AST_PBIT_SHORT   24           // parity slot, short word
`define AST_DATA_LONG    32'h7FFFFFFF // data bits under parity, long
`define AST_DATA_SHORT   32'h00FFFFFF // data bits under parity, short
`define AST_WORD_SHORT   32'h01FFFFFF // all bits of a short word
// ----------------------------------------
// register port
// ----------------------------------------
`define AST_ADR_CTRL     4'h0         // control word, read/write
`define AST_ADR_STAT     4'h1         // status, read only
`define AST_CTRL_RST     16'h0020     // loopback off after reset
`define AST_B_PARINS     4
`define AST_B_LOOP_N     5
`define AST_B_SD1        6
`define AST_B_X1         7
`define AST_B_Y1         8
`define AST_B_SD2        9
`define AST_B_X2         10
`define AST_B_Y2         11
`define AST_B_PARPOL     12
`define AST_B_TXRATE     13
`define AST_B_RXRATE     14
`define AST_B_WLEN       15
// ----------------------------------------
// pin synchroniser vector
// ----------------------------------------
`define AST_P_RX1A       0
`define AST_P_RX1B       1
`define AST_P_RX2A       2
`define AST_P_RX2B       3
`define AST_P_OE1        4
`define AST_P_OE2        5
`define AST_P_SEL        6
`define AST_P_LD1        7
`define AST_P_LD2        8
`define AST_P_GO         9
`define AST_P_B32        10
`define AST_PIN_IDLE     11'h5B0      // strobes and bit32 pin idle high
`endif

// File: rtl/ast_core.v
`include "ast_map.vh"

// Functional notes
// - triple sample, detect, confirm two ticks later
// - sample clock 1MHz high, 125kHz low
// - read reports parity error on even ones
// - code check bits 9,10 gate latching
// - latched word asserts word ready low
// - 32 bit shift, 25/32 length, then buffer
// - host reads low and high half, either order
// - ready clears on leading edge, last read
// - full buffer holds; new word waits, may overwrite
// - broken word string discards partial word
// - unframed word discarded, receiver resets
// - fifo writes ignored while transmit go high
// - ninth word overwrites last fifo entry
// - go shifts fifo out, then empty flag
// - high half load clears empty flag
// - odd/even parity replaces last bit optionally
// - two rail return to zero, never both
// - free running bit clock, high first half
// - four null bits between every word
// - short word keeps label, data, code bits
// - self test feeds tx, inverted into rx2
// - bit rate clock over 10 or 80
// - bit32 pin high forces parity insertion
// - loopback keeps line output active
// - length setting zero 32, one 25
module ast_core (
  input  wire        MCLK_IN,                  // core clock, 40 MHz
  input  wire        SRST_IN,                  // master reset, active high
  input  wire [3:0]  REG_ADDR_IN,              // register address
  input  wire [15:0] REG_WDATA_IN,             // register write data
  input  wire        REG_WR_IN,                // register write strobe
  input  wire        REG_RD_IN,                // register read strobe
  output wire [15:0] REG_RDATA_OUT,            // register read data
  input  wire        RX1_A_IN,                 // receiver 1 one rail
  input  wire        RX1_B_IN,                 // receiver 1 zero rail
  input  wire        RX2_A_IN,                 // receiver 2 one rail
  input  wire        RX2_B_IN,                 // receiver 2 zero rail
  input  wire        READ_STROBE1_N_IN,        // receiver 1 read strobe
  input  wire        READ_STROBE2_N_IN,        // receiver 2 read strobe
  input  wire        HALF_SEL_IN,              // 0 low half, 1 high half
  output wire [15:0] RX_DATA_OUT,              // half word read out
  output wire        RX_PARITY_ERR_OUT,        // parity status of read
  output wire [1:0]  WORD_READY_N_OUT,         // word ready per receiver
  input  wire [15:0] TX_DATA_IN,               // transmit load data
  input  wire        LOAD_LOW_HALF_N_IN,       // load low half strobe
  input  wire        LOAD_HIGH_HALF_N_IN,      // load high half strobe
  input  wire        TRANSMIT_GO_IN,           // transmit enable
  input  wire        BIT32_CONTROL_PIN_N_IN,   // parity slot control pin
  output wire        TRANSMIT_FIFO_EMPTY_OUT,  // fifo empty flag
  output wire        TX_RAIL_A_OUT,            // one rail out
  output wire        TX_RAIL_B_OUT,            // zero rail out
  output wire        SERIAL_BIT_CLOCK_OUT      // transmit bit clock
);

  // ----------------------------------------
  // constants and functions
  // ----------------------------------------
  localparam [8:0]  RX_DIV_HI  = `AST_RX_DIV_HI;
  localparam [8:0]  RX_DIV_LO  = `AST_RX_DIV_LO;
  localparam [10:0] TX_HALF_HI = `AST_TX_HALF_HI;
  localparam [10:0] TX_HALF_LO = `AST_TX_HALF_LO;

  // word length from the length setting
  function [5:0] ast_len;
    input sh;
    begin
      ast_len = sh ? `AST_LEN_SHORT : `AST_LEN_LONG;
    end
  endfunction

  // build the serial word with optional parity slot
  function [31:0] ast_txword;
    input [31:0] w;
    input        sh;
    input        ins;
    input        pol;
    reg   [31:0] m;
    begin
      m = w & (sh ? `AST_DATA_SHORT : `AST_DATA_LONG);
      if (!ins) begin
        ast_txword = sh ? (w & `AST_WORD_SHORT) : w;
      end else if (sh) begin
        ast_txword = m;
        ast_txword[`AST_PBIT_SHORT] = (~^m) ^ pol;
      end else begin
        ast_txword = m;
        ast_txword[`AST_PBIT_LONG] = (~^m) ^ pol;
      end
    end
  endfunction

  integer i;                                   // channel loop index

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [10:0] pin_raw = {BIT32_CONTROL_PIN_N_IN, TRANSMIT_GO_IN, LOAD_HIGH_HALF_N_IN,
                         LOAD_LOW_HALF_N_IN, HALF_SEL_IN, READ_STROBE2_N_IN,
                         READ_STROBE1_N_IN, RX2_B_IN, RX2_A_IN, RX1_B_IN, RX1_A_IN};
  reg  [10:0] s1_q;                            // first stage
  reg  [10:0] s2_q;                            // second stage
  reg  [10:0] s3_q;                            // third stage
  reg  [10:0] pin_q;                           // agreed pin level
  reg  [10:0] pin_old_q;                       // level one cycle back
  wire [10:0] agree = ~(s2_q ^ s3_q);          // stages two and three agree

  // three stages, change taken once two and three agree
  always @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      s1_q      <= `AST_PIN_IDLE;
      s2_q      <= `AST_PIN_IDLE;
      s3_q      <= `AST_PIN_IDLE;
      pin_q     <= `AST_PIN_IDLE;
      pin_old_q <= `AST_PIN_IDLE;
    end else begin
      s1_q      <= pin_raw;
      s2_q      <= s1_q;
      s3_q      <= s2_q;
      pin_q     <= (s2_q & agree) | (pin_q & ~agree);
      pin_old_q <= pin_q;
    end
  end

  // leading edges of the active low strobes
  wire [1:0] oe_fall = pin_old_q[`AST_P_OE2:`AST_P_OE1] & ~pin_q[`AST_P_OE2:`AST_P_OE1];
  wire       ld1_fall = pin_old_q[`AST_P_LD1] & ~pin_q[`AST_P_LD1];
  wire       ld2_fall = pin_old_q[`AST_P_LD2] & ~pin_q[`AST_P_LD2];
  wire       go = pin_q[`AST_P_GO];
  wire [1:0] sel_mask = pin_q[`AST_P_SEL] ? 2'h2 : 2'h1;

  // ----------------------------------------
  // control register and register port
  // ----------------------------------------
  reg  [15:0] ctrl_q;                          // control word
  reg  [15:0] rdata_q;                         // read data
  reg  [1:0]  rdy_n_q;                         // word ready, active low
  reg         empty_q;                         // fifo empty flag
  reg  [3:0]  cnt_q;                           // words in fifo
  wire        wlen = ctrl_q[`AST_B_WLEN];
  wire        loop_n = ctrl_q[`AST_B_LOOP_N];
  wire [5:0]  len = ast_len(wlen);
  wire [1:0]  sd_on = {ctrl_q[`AST_B_SD2], ctrl_q[`AST_B_SD1]};
  wire [1:0]  sd_x = {ctrl_q[`AST_B_X2], ctrl_q[`AST_B_X1]};
  wire [1:0]  sd_y = {ctrl_q[`AST_B_Y2], ctrl_q[`AST_B_Y1]};

  // write control, answer reads one cycle later
  always @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      ctrl_q  <= `AST_CTRL_RST;
      rdata_q <= 16'h0000;
    end else begin
      if (REG_WR_IN && REG_ADDR_IN == `AST_ADR_CTRL) begin
        ctrl_q <= REG_WDATA_IN;
      end
      if (REG_RD_IN) begin
        case (REG_ADDR_IN)
          `AST_ADR_CTRL: rdata_q <= ctrl_q;
          `AST_ADR_STAT: rdata_q <= {9'h000, rdy_n_q, empty_q, cnt_q};
          default:       rdata_q <= 16'h0000;  // unmapped reads zero
        endcase
      end else begin
        rdata_q <= 16'h0000;
      end
    end
  end

  // ----------------------------------------
  // receive sample clock
  // ----------------------------------------
  reg  [8:0] rc_q;                             // sample divider
  wire [8:0] rx_div = ctrl_q[`AST_B_RXRATE] ? RX_DIV_LO : RX_DIV_HI;
  wire       rx_tick = (rc_q == rx_div - 9'h001);

  // one tick every sample period
  always @(posedge MCLK_IN) begin
    if (SRST_IN || rx_tick) begin
      rc_q <= 9'h000;
    end else begin
      rc_q <= rc_q + 9'h001;
    end
  end

  // ----------------------------------------
  // receivers
  // ----------------------------------------
  reg        tx_a_q;                           // tx one rail
  reg        tx_b_q;                           // tx zero rail
  // self test: tx into rx1, complement (rails swapped) into rx2
  wire [1:0] ra = loop_n ? {pin_q[`AST_P_RX2A], pin_q[`AST_P_RX1A]} : {tx_b_q, tx_a_q};
  wire [1:0] rb = loop_n ? {pin_q[`AST_P_RX2B], pin_q[`AST_P_RX1B]} : {tx_a_q, tx_b_q};
  reg [1:0]  run_q   [0:1];                    // consecutive active samples
  reg [4:0]  idle_q  [0:1];                    // idle samples
  reg        pre_q   [0:1];                    // null seen before bit
  reg        act_q   [0:1];                    // word in progress
  reg [5:0]  bcnt_q  [0:1];                    // bits received
  reg [31:0] sr_q    [0:1];                    // shift register
  reg [31:0] buf_q   [0:1];                    // receive buffer
  reg        pend_q  [0:1];                    // word waits in shift register
  reg [1:0]  got_q   [0:1];                    // halves read
  reg [15:0] rx_data_q;                        // read data out
  reg        par_err_q;                        // parity status out

  // host reads, word assembly, framing and latching
  always @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      for (i = 0; i < 2; i = i + 1) begin
        run_q[i]  <= 2'h0;
        idle_q[i] <= `AST_IDLE_MAX;
        pre_q[i]  <= 1'b0;
        act_q[i]  <= 1'b0;
        bcnt_q[i] <= 6'h00;
        sr_q[i]   <= 32'h00000000;
        buf_q[i]  <= 32'h00000000;
        pend_q[i] <= 1'b0;
        got_q[i]  <= 2'h0;
        rdy_n_q[i] <= 1'b1;
      end
      rx_data_q <= 16'h0000;
      par_err_q <= 1'b0;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        // read one half on the strobe's leading edge
        if (oe_fall[i]) begin
          rx_data_q <= pin_q[`AST_P_SEL] ? buf_q[i][31:16] : buf_q[i][15:0];
          par_err_q <= ~^buf_q[i];
          if ((got_q[i] | sel_mask) == 2'h3) begin
            got_q[i]   <= 2'h0;
            rdy_n_q[i] <= 1'b1;
          end else begin
            got_q[i] <= got_q[i] | sel_mask;
          end
        end else if (pend_q[i] && rdy_n_q[i]) begin
          // buffer freed, move the waiting word in
          buf_q[i]   <= sr_q[i];
          rdy_n_q[i] <= 1'b0;
          pend_q[i]  <= 1'b0;
          got_q[i]   <= 2'h0;
        end
        if (rx_tick) begin
          if (ra[i] | rb[i]) begin
            // rail active: detect, then confirm
            idle_q[i] <= 5'h00;
            if (run_q[i] != 2'h3) begin
              run_q[i] <= run_q[i] + 2'h1;
            end
            if (run_q[i] == 2'h0) begin
              pre_q[i] <= (idle_q[i] >= `AST_NULL_TICKS);
            end
            if (run_q[i] == `AST_CONFIRM) begin
              if (act_q[i]) begin
                if (bcnt_q[i] == len) begin
                  act_q[i] <= 1'b0;
                end else begin
                  sr_q[i][bcnt_q[i][4:0]] <= ra[i];
                  bcnt_q[i] <= bcnt_q[i] + 6'h01;
                end
              end else if (pre_q[i]) begin
                // first bit of a new word
                act_q[i]  <= 1'b1;
                bcnt_q[i] <= 6'h01;
                sr_q[i]   <= {31'h00000000, ra[i]};
                pend_q[i] <= 1'b0;
              end
            end
          end else begin
            // rail idle: count null time
            run_q[i] <= 2'h0;
            if (idle_q[i] != `AST_IDLE_MAX) begin
              idle_q[i] <= idle_q[i] + 5'h01;
            end
            if (act_q[i] && idle_q[i] == `AST_BREAK_TICKS && bcnt_q[i] != len) begin
              act_q[i] <= 1'b0;
            end
            if (act_q[i] && idle_q[i] == `AST_NULL_TICKS && bcnt_q[i] == len) begin
              act_q[i] <= 1'b0;
              // code check, bits 9 and 10
              if (!sd_on[i] || (sr_q[i][`AST_SD_X] == sd_x[i] &&
                                sr_q[i][`AST_SD_Y] == sd_y[i])) begin
                if (!rdy_n_q[i]) begin
                  pend_q[i] <= 1'b1;
                end else begin
                  buf_q[i]   <= sr_q[i];
                  rdy_n_q[i] <= 1'b0;
                  got_q[i]   <= 2'h0;
                end
              end
            end
          end
        end
      end
    end
  end

  // ----------------------------------------
  // transmit fifo
  // ----------------------------------------
  reg [31:0] mem [0:7];                        // 8 x 32 word store
  reg [2:0]  wr_q;                             // write pointer
  reg [2:0]  rd_q;                             // read pointer
  reg [15:0] lo_q;                             // low half hold
  reg [10:0] hc_q;                             // half bit timer
  reg        bclk_q;                           // bit clock
  reg [31:0] tsr_q;                            // transmit shift register
  reg [5:0]  tbits_q;                          // bits left in word
  reg [2:0]  gap_q;                            // null bits left
  wire [10:0] half = ctrl_q[`AST_B_TXRATE] ? TX_HALF_LO : TX_HALF_HI;
  wire        half_end = (hc_q == half - 11'h001);
  wire        ins = pin_q[`AST_P_B32] | ctrl_q[`AST_B_PARINS];
  wire [31:0] nxt = ast_txword(mem[rd_q], wlen, ins, ctrl_q[`AST_B_PARPOL]);

  // fifo loading, bit timing and serial output
  always @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      wr_q    <= 3'h0;
      rd_q    <= 3'h0;
      cnt_q   <= 4'h0;
      lo_q    <= 16'h0000;
      empty_q <= 1'b1;
      hc_q    <= 11'h000;
      bclk_q  <= 1'b0;
      tsr_q   <= 32'h00000000;
      tbits_q <= 6'h00;
      gap_q   <= 3'h0;
      tx_a_q  <= 1'b0;
      tx_b_q  <= 1'b0;
    end else begin
      // loads accepted only while go is low
      if (ld1_fall && !go) begin
        lo_q <= TX_DATA_IN;
      end
      if (ld2_fall && !go) begin
        empty_q <= 1'b0;
        if (cnt_q == `AST_FIFO_FULL) begin
          mem[wr_q - 3'h1] <= {TX_DATA_IN, lo_q};
        end else begin
          mem[wr_q] <= {TX_DATA_IN, lo_q};
          wr_q  <= wr_q + 3'h1;
          cnt_q <= cnt_q + 4'h1;
        end
      end
      // free running half bit timer
      hc_q <= half_end ? 11'h000 : hc_q + 11'h001;
      if (half_end) begin
        if (bclk_q) begin
          // second half: return to zero
          bclk_q <= 1'b0;
          tx_a_q <= 1'b0;
          tx_b_q <= 1'b0;
        end else begin
          bclk_q <= 1'b1;
          if (tbits_q != 6'h00) begin
            // next bit of current word
            tx_a_q  <= tsr_q[0];
            tx_b_q  <= ~tsr_q[0];
            tsr_q   <= tsr_q >> 1;
            tbits_q <= tbits_q - 6'h01;
            if (tbits_q == 6'h01) begin
              gap_q <= `AST_GAP_BITS;
            end
          end else if (gap_q != 3'h0) begin
            // null bit of the word gap
            tx_a_q <= 1'b0;
            tx_b_q <= 1'b0;
            gap_q  <= gap_q - 3'h1;
            if (gap_q == `AST_GAP_BITS && cnt_q == 4'h0) begin
              empty_q <= 1'b1;
            end
          end else if (go && cnt_q != 4'h0) begin
            // start next word, first bit now
            tx_a_q  <= nxt[0];
            tx_b_q  <= ~nxt[0];
            tsr_q   <= nxt >> 1;
            tbits_q <= len - 6'h01;
            rd_q    <= rd_q + 3'h1;
            cnt_q   <= cnt_q - 4'h1;
          end else begin
            tx_a_q <= 1'b0;
            tx_b_q <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign REG_RDATA_OUT           = rdata_q;
  assign RX_DATA_OUT             = rx_data_q;
  assign RX_PARITY_ERR_OUT       = par_err_q;
  assign WORD_READY_N_OUT        = rdy_n_q;
  assign TRANSMIT_FIFO_EMPTY_OUT = empty_q;
  assign TX_RAIL_A_OUT           = tx_a_q;
  assign TX_RAIL_B_OUT           = tx_b_q;
  assign SERIAL_BIT_CLOCK_OUT    = bclk_q;

endmodule // ast_core

// File: rtl/dummy_none.v
// ----------------------------------------
// intentionally empty
// ----------------------------------------

// File: bench/ast_core_props.sv
module ast_core_props (
  input wire        MCLK_IN,                  // core clock
  input wire        SRST_IN,                  // reset
  input wire        REG_RD_IN,                // register read strobe
  input wire [15:0] REG_RDATA_OUT,            // register read data
  input wire        READ_STROBE1_N_IN,        // rx1 read strobe
  input wire        READ_STROBE2_N_IN,        // rx2 read strobe
  input wire [1:0]  WORD_READY_N_OUT,         // word ready flags
  input wire        LOAD_HIGH_HALF_N_IN,      // high half load strobe
  input wire        TRANSMIT_GO_IN,           // transmit enable
  input wire        TRANSMIT_FIFO_EMPTY_OUT,  // fifo empty flag
  input wire        TX_RAIL_A_OUT,            // one rail
  input wire        TX_RAIL_B_OUT,            // zero rail
  input wire        SERIAL_BIT_CLOCK_OUT      // bit clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_q;  // bit clock one cycle ago
  logic [11:0] run_q;  // length of the current bit clock level
  // measure how long the bit clock holds a level
  always @(posedge MCLK_IN) begin
    clk_q <= SERIAL_BIT_CLOCK_OUT;
    run_q <= (SERIAL_BIT_CLOCK_OUT != clk_q) ? 12'h001 : run_q + 12'h001;
  end
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (SRST_IN);
  AST_RAILS: assert property (!(TX_RAIL_A_OUT && TX_RAIL_B_OUT))
    else $error("both rails high");
  AST_RZ_HALF: assert property ((TX_RAIL_A_OUT || TX_RAIL_B_OUT) |-> SERIAL_BIT_CLOCK_OUT)
    else $error("rail pulse outside first half");
  AST_CLK_HIGH: assert property ((!SERIAL_BIT_CLOCK_OUT && clk_q) |-> (run_q == 12'h0C8 || run_q == 12'h640))
    else $error("bit clock high phase wrong");
  AST_RDY1_CLR: assert property ($rose(WORD_READY_N_OUT[0]) |-> !READ_STROBE1_N_IN)
    else $error("rx1 ready cleared without read");
  AST_RDY2_CLR: assert property ($rose(WORD_READY_N_OUT[1]) |-> !READ_STROBE2_N_IN)
    else $error("rx2 ready cleared without read");
  AST_EMPTY_CLR: assert property ($fell(TRANSMIT_FIFO_EMPTY_OUT) |-> (!LOAD_HIGH_HALF_N_IN && !TRANSMIT_GO_IN))
    else $error("empty cleared without high load");
  AST_EMPTY_SET: assert property ($rose(TRANSMIT_FIFO_EMPTY_OUT) |-> (TRANSMIT_GO_IN && !TX_RAIL_A_OUT && !TX_RAIL_B_OUT) [*8])
    else $error("empty set outside a null gap");
  AST_RDATA_IDLE: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 16'h0000)
    else $error("read data outside read cycle");
  cover property ($fell(WORD_READY_N_OUT[0]));
  cover property ($fell(WORD_READY_N_OUT[1]));
  cover property ($rose(TRANSMIT_FIFO_EMPTY_OUT));
endmodule // ast_core_props

// File: bench/ast_line_model.sv
module ast_line_model (
  input  wire  clk_in,      // core clock
  output logic rail_a_out,  // one rail
  output logic rail_b_out   // zero rail
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rail_a_out = 1'b0;
  initial rail_b_out = 1'b0;
  // send n bits, bit 1 first, each a half-bit pulse, then a long null gap
  task automatic send(input logic [31:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      rail_a_out <= w[i];
      rail_b_out <= ~w[i];
      repeat (200) @(posedge clk_in);
      rail_a_out <= 1'b0;
      rail_b_out <= 1'b0;
      repeat (199) @(posedge clk_in);
    end
    repeat (800) @(posedge clk_in);
  endtask
endmodule // ast_line_model

// File: bench/ast_core_tb.sv
module ast_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, sel = 1'b0, go = 1'b0, b32 = 1'b1;
  logic        ld1_n = 1'b1, ld2_n = 1'b1, perr, empty, ra, rb, ta, tb_r, sclk;
  logic [1:0]  oe_n = 2'b11, rdy_n;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, txd = 16'h0000, rdata, rxd;
  logic [31:0] w3 = 32'h1234_5678, w4 = 32'h8000_0001, e3;
  int          error_cnt = 0, check_count = 0;
  ast_line_model u_ast_line_model (.clk_in(clk), .rail_a_out(ra), .rail_b_out(rb));
  ast_core u_ast_core (.MCLK_IN(clk), .SRST_IN(srst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .RX1_A_IN(ra), .RX1_B_IN(rb),
    .RX2_A_IN(1'b0), .RX2_B_IN(1'b0), .READ_STROBE1_N_IN(oe_n[0]), .READ_STROBE2_N_IN(oe_n[1]),
    .HALF_SEL_IN(sel), .RX_DATA_OUT(rxd), .RX_PARITY_ERR_OUT(perr), .WORD_READY_N_OUT(rdy_n),
    .TX_DATA_IN(txd), .LOAD_LOW_HALF_N_IN(ld1_n), .LOAD_HIGH_HALF_N_IN(ld2_n), .TRANSMIT_GO_IN(go),
    .BIT32_CONTROL_PIN_N_IN(b32), .TRANSMIT_FIFO_EMPTY_OUT(empty), .TX_RAIL_A_OUT(ta),
    .TX_RAIL_B_OUT(tb_r), .SERIAL_BIT_CLOCK_OUT(sclk));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 1'b0;
    #1 chk("register", exp, rdata);
  endtask
  // one half read: select settles, strobe pulses, then data and parity compared
  task automatic rx_rd(input int ch, input logic s, input logic [15:0] exp, input logic ep);
    @(posedge clk) sel <= s;
    repeat (5) @(posedge clk);
    oe_n[ch] <= 1'b0;
    repeat (8) @(posedge clk);
    oe_n[ch] <= 1'b1;
    repeat (8) @(posedge clk);
    chk("rx data", exp, rxd);
    chk("rx parity", {15'h0, ep}, {15'h0, perr});
  endtask
  task automatic load(input logic [31:0] w);
    @(posedge clk) {txd, ld1_n} <= {w[15:0], 1'b0};
    repeat (8) @(posedge clk);
    ld1_n <= 1'b1;
    repeat (8) @(posedge clk);
    {txd, ld2_n} <= {w[31:16], 1'b0};
    repeat (8) @(posedge clk);
    ld2_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic wait_rdy(input logic [1:0] want);
    int n;
    n = 0;
    while (rdy_n !== want && n < 40000) begin
      @(posedge clk);
      n++;
    end
    chk("ready", {14'h0, want}, {14'h0, rdy_n});
    if (n >= 40000) print_verdict();
  endtask
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    reg_rd(4'h1, 16'h0070);
    reg_rd(4'h0, 16'h0020);
    reg_rd(4'h7, 16'h0000);
    $display("test reset done");
    reg_wr(4'h0, 16'h01E0);
    reg_wr(4'h3, 16'hFFFF);
    reg_rd(4'h0, 16'h01E0);
    u_ast_line_model.send(32'hA5C3_0C12, 32);
    chk("ready", 16'h0003, {14'h0, rdy_n});
    u_ast_line_model.send(32'hA5C3_0F12, 32);
    wait_rdy(2'b10);
    rx_rd(0, 1'b0, 16'h0F12, ~^32'hA5C3_0F12);
    chk("ready", 16'h0002, {14'h0, rdy_n});
    rx_rd(0, 1'b1, 16'hA5C3, ~^32'hA5C3_0F12);
    chk("ready", 16'h0003, {14'h0, rdy_n});
    $display("test line receive done");
    reg_wr(4'h0, 16'h0000);
    load(w3);
    reg_rd(4'h1, 16'h0061);
    @(posedge clk) go <= 1'b1;
    e3 = {~^w3[30:0], w3[30:0]};
    wait_rdy(2'b00);
    chk("empty", 16'h0001, {15'h0, empty});
    rx_rd(0, 1'b0, e3[15:0], 1'b0);
    rx_rd(0, 1'b1, e3[31:16], 1'b0);
    rx_rd(1, 1'b0, ~e3[15:0], 1'b0);
    rx_rd(1, 1'b1, ~e3[31:16], 1'b0);
    chk("ready", 16'h0003, {14'h0, rdy_n});
    $display("test loopback done");
    load(32'hFFFF_FFFF);
    reg_rd(4'h1, 16'h0070);
    @(posedge clk) {go, b32} <= 2'b00;
    repeat (8) @(posedge clk);
    load(w4);
    reg_rd(4'h1, 16'h0061);
    @(posedge clk) go <= 1'b1;
    wait_rdy(2'b00);
    rx_rd(0, 1'b0, w4[15:0], ~^w4);
    rx_rd(0, 1'b1, w4[31:16], ~^w4);
    $display("test parity pin done");
    print_verdict();
  end
endmodule // ast_core_tb
bind ast_core ast_core_props u_chk (.MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN), .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .READ_STROBE1_N_IN(READ_STROBE1_N_IN), .READ_STROBE2_N_IN(READ_STROBE2_N_IN),
  .WORD_READY_N_OUT(WORD_READY_N_OUT), .LOAD_HIGH_HALF_N_IN(LOAD_HIGH_HALF_N_IN), .TRANSMIT_GO_IN(TRANSMIT_GO_IN),
  .TRANSMIT_FIFO_EMPTY_OUT(TRANSMIT_FIFO_EMPTY_OUT), .TX_RAIL_A_OUT(TX_RAIL_A_OUT), .TX_RAIL_B_OUT(TX_RAIL_B_OUT),
  .SERIAL_BIT_CLOCK_OUT(SERIAL_BIT_CLOCK_OUT));
